/* logic/ecc_counter.sv */
// 32-bit signed encoder counter core with Avalon-MM register slave,
// gate control, overflow flags, comparison output with hysteresis and
// pulse stretching.
// Assumes encoder, gate and reset pins are asynchronous to CLK_IN.
//
// How it works
// - Output drives only with output enable set
// - Reset input acts only with reset enable
// - Evaluation field selects off/single/double/quad/pulse
// - Mode bit 7 picks abort or interrupt
// - Evaluation off: no counting, settings ignored
// - Hardware gate off: software gate alone starts
// - Hardware gate on: both gates must open
// - Hysteresis 0..255; 0 and 1 disable
// - Pulse setting counts 2.048 ms steps
// - Nonzero pulse holds output programmed time
// - Zero pulse follows comparison condition
// - No main direction: full signed range
// - Forward: reload after end minus one
// - Backward: reload after end plus one
// - Gate behaviour applies to hardware gate, or to software gate with hardware gate off
// - Abort: reopening gate reloads load value
// - Interrupt: reopening gate keeps held count
// - Endless mode starts from load value
// - Up past maximum wraps to minimum
// - Down past minimum wraps to maximum
// - Endless limits fixed at full range
// - Sticky flow flags, cleared by host
// - Interrupt bits 2, 3 enable; bit 7 fixed
// - Mode two bits 2..0 choose output condition
//
// The Avalon-MM register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module ecc_counter
    import ecc_pkg::*;
#(
    parameter int PULSE_UNIT_CYCLES = PULSE_STEP_CYCLES
) (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    // Avalon-MM slave
    input wire logic [5:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    input wire logic [3:0] AVS_BYTEENABLE_IN,
    output logic [31:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT,
    // Encoder and control pins
    input wire logic ENC_A_IN,
    input wire logic ENC_B_IN,
    input wire logic GATE_IN,
    input wire logic CNT_RESET_IN,
    // Results
    output logic DIG_OUT,
    output logic PROC_IRQ_OUT
);

    ////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [1:0] a_sync;
        logic [1:0] b_sync;
        logic [1:0] g_sync;
        logic [1:0] r_sync;
        logic a_old;
        logic b_old;
        logic r_old;
        logic hw_old;
        logic igate_old;
        logic ctrl_rst_en;
        logic ctrl_out_en;
        logic software_gate;
        logic [7:0] mode_two;
        logic [7:0] mode_three;
        logic [7:0] int_behav;
        logic [31:0] end_value;
        logic [31:0] load_value;
        logic [7:0] hyst;
        logic [7:0] pulse;
        logic [31:0] cmp_value;
        logic [1:0] dir_sel;
        logic [31:0] count;
        logic ovf;
        logic unf;
        logic started;
        logic reset_done;
        logic cond_hold;
        logic [PULSE_TIMER_W-1:0] pulse_timer;
        logic [7:0] flow_quiet;
        logic dout;
        logic irq;
        logic ack;
        logic [31:0] rdata;
    } ecc_state_t;
    ecc_state_t s;
    ecc_state_t next_s;
    // Byte-lane merge for every writable register
    function automatic logic [31:0] ecc_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : ecc_merge
    // Distance between count and comparison value
    function automatic logic [32:0] ecc_dist(input logic [31:0] x,
                                             input logic [31:0] y);
        logic [32:0] d;
        d = {x[31], x} - {y[31], y};
        return d[32] ? (33'h0_0000_0000 - d) : d;
    endfunction : ecc_dist

    ////////////////////////////////////////////////////////////////////
    // Combinational helpers shared with the checks
    logic req;
    logic take;
    logic [2:0] evalm;
    logic hw_en;
    logic hw_open;
    logic igate;
    logic cnt_pulse;
    logic cnt_up;
    logic cnt_en;
    logic rst_fire;
    logic gate_load;
    logic raw_cond;
    logic ovf_ev;
    logic unf_ev;
    logic sts_clr;
    logic [31:0] wmerged;
    logic [31:0] rd_mux;
    logic [31:0] timer_load;
    always_comb begin
        next_s = s;
        // Two-stage synchronisers; old copies read the second stage only
        next_s.a_sync = {s.a_sync[0], ENC_A_IN};
        next_s.b_sync = {s.b_sync[0], ENC_B_IN};
        next_s.g_sync = {s.g_sync[0], GATE_IN};
        next_s.r_sync = {s.r_sync[0], CNT_RESET_IN};
        next_s.a_old = s.a_sync[1];
        next_s.b_old = s.b_sync[1];
        next_s.r_old = s.r_sync[1];
        // Bus handshake: one wait cycle, read data latched during it
        req = AVS_READ_IN | AVS_WRITE_IN;
        take = req & s.ack;
        next_s.ack = req & ~s.ack;
        wmerged = RST_WORD;
        unique case (AVS_ADDRESS_IN)
            OFS_CONTROL: rd_mux = {30'h0000_0000, s.ctrl_out_en, s.ctrl_rst_en};
            OFS_MODE_TWO: rd_mux = {24'h00_0000, s.mode_two};
            OFS_MODE_THREE: rd_mux = {24'h00_0000, s.mode_three};
            OFS_INT_BEHAV: rd_mux = {24'h00_0000, s.int_behav};
            OFS_END: rd_mux = s.end_value;
            OFS_LOAD: rd_mux = s.load_value;
            OFS_HYST: rd_mux = {24'h00_0000, s.hyst};
            OFS_PULSE: rd_mux = {24'h00_0000, s.pulse};
            OFS_COMPARE: rd_mux = s.cmp_value;
            OFS_COUNT: rd_mux = s.count;
            OFS_STATUS: rd_mux = {27'h000_0000, s.software_gate, s.igate_old, s.dout,
                                  s.unf, s.ovf};
            OFS_DIRECTION: rd_mux = {30'h0000_0000, s.dir_sel};
            default: rd_mux = RST_WORD; // Unmapped reads as zero
        endcase
        if (req & ~s.ack) begin
            next_s.rdata = AVS_READ_IN ? rd_mux : RST_WORD;
        end
        // Register writes commit on the edge where waitrequest is low
        sts_clr = 1'b0;
        if (take & AVS_WRITE_IN) begin
            unique case (AVS_ADDRESS_IN)
                OFS_CONTROL: begin
                    wmerged = ecc_merge(RST_WORD, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
                    next_s.ctrl_rst_en = wmerged[CTL_RESET_EN];
                    next_s.ctrl_out_en = wmerged[CTL_OUT_EN];
                    if (wmerged[CTL_SW_SET]) begin
                        next_s.software_gate = 1'b1;
                    end else if (wmerged[CTL_SW_CLR]) begin
                        next_s.software_gate = 1'b0;
                    end
                    sts_clr = wmerged[CTL_STS_CLR];
                end
                OFS_MODE_TWO: begin
                    wmerged = ecc_merge({24'h00_0000, s.mode_two}, AVS_WRITEDATA_IN,
                                        AVS_BYTEENABLE_IN);
                    next_s.mode_two = wmerged[7:0];
                end
                OFS_MODE_THREE: begin
                    wmerged = ecc_merge({24'h00_0000, s.mode_three}, AVS_WRITEDATA_IN,
                                        AVS_BYTEENABLE_IN);
                    next_s.mode_three = wmerged[7:0];
                end
                OFS_INT_BEHAV: begin
                    wmerged = ecc_merge({24'h00_0000, s.int_behav}, AVS_WRITEDATA_IN,
                                        AVS_BYTEENABLE_IN);
                    next_s.int_behav = wmerged[7:0] | INT_FIXED;
                end
                OFS_END: next_s.end_value = ecc_merge(s.end_value, AVS_WRITEDATA_IN,
                                                      AVS_BYTEENABLE_IN);
                OFS_LOAD: next_s.load_value = ecc_merge(s.load_value, AVS_WRITEDATA_IN,
                                                        AVS_BYTEENABLE_IN);
                OFS_HYST: begin
                    wmerged = ecc_merge({24'h00_0000, s.hyst}, AVS_WRITEDATA_IN,
                                        AVS_BYTEENABLE_IN);
                    next_s.hyst = wmerged[7:0];
                end
                OFS_PULSE: begin
                    wmerged = ecc_merge({24'h00_0000, s.pulse}, AVS_WRITEDATA_IN,
                                        AVS_BYTEENABLE_IN);
                    next_s.pulse = wmerged[7:0];
                end
                OFS_COMPARE: next_s.cmp_value = ecc_merge(s.cmp_value, AVS_WRITEDATA_IN,
                                                          AVS_BYTEENABLE_IN);
                OFS_DIRECTION: begin
                    wmerged = ecc_merge({30'h0000_0000, s.dir_sel}, AVS_WRITEDATA_IN,
                                        AVS_BYTEENABLE_IN);
                    next_s.dir_sel = wmerged[1:0];
                end
                default: wmerged = RST_WORD; // Unmapped and read-only: ignored
            endcase
        end
        // Track decoding; B may be inverted by mode two
        evalm = s.mode_three[2:0];
        cnt_pulse = 1'b0;
        cnt_up = 1'b0;
        unique case (evalm)
            EV_SINGLE: begin
                cnt_pulse = s.a_sync[1] & ~s.a_old;
                cnt_up = ~(s.b_sync[1] ^ s.mode_two[M2_INV_B]);
            end
            EV_DOUBLE: begin
                cnt_pulse = s.a_sync[1] ^ s.a_old;
                cnt_up = s.a_sync[1] ^ s.b_sync[1] ^ s.mode_two[M2_INV_B];
            end
            EV_QUAD: begin
                cnt_pulse = (s.a_sync[1] ^ s.a_old) ^ (s.b_sync[1] ^ s.b_old);
                cnt_up = s.a_sync[1] ^ s.b_old ^ s.mode_two[M2_INV_B];
            end
            EV_PULSE: begin
                cnt_pulse = s.a_sync[1] & ~s.a_old;
                cnt_up = ~(s.b_sync[1] ^ s.mode_two[M2_INV_B]);
            end
            default: cnt_pulse = 1'b0;
        endcase
        // Internal gate is the AND of both gates
        hw_en = (s.mode_three[6:3] == HWG_ON);
        hw_open = hw_en ? s.g_sync[1] : 1'b1;
        igate = s.software_gate & hw_open & (evalm != EV_OFF);
        next_s.hw_old = hw_open;
        next_s.igate_old = igate;
        cnt_en = igate & cnt_pulse;
        // Abort reloads on openings caused by the hardware gate, or on any opening with it off
        gate_load = igate & ~s.igate_old &
                    (~s.started | (~s.mode_three[M3_GATE_FN] &
                                   (~hw_en | ~s.hw_old)));
        // Counter reset input, ignored unless enabled
        rst_fire = 1'b0;
        if (s.ctrl_rst_en & (evalm != EV_OFF)) begin
            unique case (s.mode_two[6:4])
                RST_LEVEL: rst_fire = s.r_sync[1];
                RST_EDGE: rst_fire = s.r_sync[1] & ~s.r_old;
                RST_ONCE: rst_fire = s.r_sync[1] & ~s.r_old & ~s.reset_done;
                default: rst_fire = 1'b0;
            endcase
        end
        if (rst_fire) begin
            next_s.reset_done = 1'b1;
        end else if (~s.ctrl_rst_en) begin
            next_s.reset_done = 1'b0;
        end
        // Count update with wrap and main-direction reload
        ovf_ev = 1'b0;
        unf_ev = 1'b0;
        if (rst_fire | gate_load) begin
            next_s.count = s.load_value;
            next_s.started = 1'b1;
        end else if (cnt_en & cnt_up) begin
            if ((s.dir_sel == DIR_FWD) && (s.count == s.end_value - 32'h0000_0001)) begin
                next_s.count = s.load_value;
            end else if (s.count == CNT_MAX) begin
                next_s.count = CNT_MIN;
                ovf_ev = 1'b1;
            end else begin
                next_s.count = s.count + 32'h0000_0001;
            end
        end else if (cnt_en) begin
            if ((s.dir_sel == DIR_BWD) && (s.count == s.end_value + 32'h0000_0001)) begin
                next_s.count = s.load_value;
            end else if (s.count == CNT_MIN) begin
                next_s.count = CNT_MAX;
                unf_ev = 1'b1;
            end else begin
                next_s.count = s.count - 32'h0000_0001;
            end
        end
        // Sticky flags; a flow event beats a clear in the same cycle
        next_s.ovf = ovf_ev | (s.ovf & ~sts_clr);
        next_s.unf = unf_ev | (s.unf & ~sts_clr);
        // Flow interrupts held off until hysteresis-many pulses have passed
        next_s.irq = 1'b0;
        if (ovf_ev | unf_ev) begin
            next_s.flow_quiet = 8'h00;
            next_s.irq = ((ovf_ev & s.int_behav[INT_OVF]) |
                          (unf_ev & s.int_behav[INT_UNF])) &
                         ((s.hyst < HYST_MIN_ON) | (s.flow_quiet >= s.hyst));
        end else if (cnt_en && (s.flow_quiet != 8'hFF)) begin
            next_s.flow_quiet = s.flow_quiet + 8'h01;
        end
        // Comparison; releases only once the count leaves the hysteresis band
        unique case (s.mode_two[2:0])
            CMP_GE: raw_cond = $signed(s.count) >= $signed(s.cmp_value);
            CMP_LE: raw_cond = $signed(s.count) <= $signed(s.cmp_value);
            CMP_EQ: raw_cond = s.count == s.cmp_value;
            default: raw_cond = 1'b0;
        endcase
        if (raw_cond) begin
            next_s.cond_hold = 1'b1;
        end else if ((s.hyst < HYST_MIN_ON) ||
                     (ecc_dist(s.count, s.cmp_value) >= {25'h000_0000, s.hyst})) begin
            next_s.cond_hold = 1'b0;
        end
        // Pulse stretcher in 2.048 ms steps
        timer_load = 32'(s.pulse) * 32'(PULSE_UNIT_CYCLES);
        if ((s.pulse != 8'h00) & next_s.cond_hold & ~s.cond_hold) begin
            next_s.pulse_timer = timer_load[PULSE_TIMER_W-1:0];
        end else if (s.pulse_timer != '0) begin
            next_s.pulse_timer = s.pulse_timer - PULSE_TIMER_W'(1);
        end
        next_s.dout = next_s.ctrl_out_en &
                      ((next_s.pulse == 8'h00) ? next_s.cond_hold
                                               : (next_s.pulse_timer != '0));
    end

    ////////////////////////////////////////////////////////////////////
    // State register; every field returns to a constant on reset
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            s <= '0;
            s.int_behav <= INT_FIXED;
        end else begin
            s <= next_s;
        end
    end
    // Outputs come straight from flip-flops except the wait signal
    assign AVS_WAITREQUEST_OUT = req & ~s.ack;
    assign AVS_READDATA_OUT = s.rdata;
    assign DIG_OUT = s.dout;
    assign PROC_IRQ_OUT = s.irq;

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking ecc_cb @(posedge CLK_IN);
    endclocking
    default disable iff (RESET_IN);
    chk_out_enable_gate: assert property (~s.ctrl_out_en |-> ~DIG_OUT)
        else $error("output active while output enable clear");
    chk_reset_loads: assert property (rst_fire |=> s.count == $past(s.load_value))
        else $error("counter reset did not load the load value");
    chk_reset_needs_en: assert property (~s.ctrl_rst_en |-> ~rst_fire)
        else $error("reset input acted without reset enable");
    chk_disabled_holds: assert property ((evalm == EV_OFF) |=> $stable(s.count))
        else $error("count moved while counter disabled");
    chk_wrap_up: assert property (cnt_en && cnt_up && ~rst_fire && ~gate_load &&
        s.dir_sel == DIR_NONE && s.count == CNT_MAX |=> s.count == CNT_MIN && s.ovf)
        else $error("up wrap at maximum failed");
    chk_wrap_down: assert property (cnt_en && ~cnt_up && ~rst_fire && ~gate_load &&
        s.dir_sel == DIR_NONE && s.count == CNT_MIN |=> s.count == CNT_MAX && s.unf)
        else $error("down wrap at minimum failed");
    chk_fwd_reload: assert property (cnt_en && cnt_up && ~rst_fire && ~gate_load &&
        s.dir_sel == DIR_FWD && s.count == s.end_value - 32'h0000_0001
        |=> s.count == $past(s.load_value))
        else $error("forward reload at end value failed");
    chk_flag_sticky: assert property (s.ovf && ~sts_clr |=> s.ovf)
        else $error("overflow flag dropped without clear");
    chk_abort_reload: assert property (igate && ~s.igate_old && ~rst_fire &&
        ~s.mode_three[M3_GATE_FN] && ~hw_en |=> s.count == $past(s.load_value))
        else $error("abort gate did not reload");
    chk_pulse_load: assert property ((s.pulse != 8'h00) && next_s.cond_hold &&
        ~s.cond_hold |=> 32'(s.pulse_timer) == $past(timer_load) && DIG_OUT == s.ctrl_out_en)
        else $error("pulse timer not loaded with programmed duration");
    chk_bus_answer: assert property (req && ~s.ack |=> req |-> ~AVS_WAITREQUEST_OUT)
        else $error("bus request not answered after one wait cycle");
    cov_wrap_up: cover property (ovf_ev ##1 s.ovf);
    cov_wrap_down: cover property (unf_ev ##1 s.unf);
    cov_gate_reload: cover property (gate_load && s.started);
    cov_pulse_out: cover property ($rose(DIG_OUT) && s.pulse != 8'h00);

endmodule : ecc_counter
`default_nettype wire

/* logic/ecc_pkg.sv */
// Constants for the 32-bit encoder counter core: register map, field
// positions, reset values, encodings and timing counts.
// Assumes a 100 MHz system clock and a 32-bit Avalon-MM register port.
package ecc_pkg;
    // Register byte addresses
    localparam logic [5:0] OFS_CONTROL = 6'h00;
    localparam logic [5:0] OFS_MODE_TWO = 6'h04;
    localparam logic [5:0] OFS_MODE_THREE = 6'h08;
    localparam logic [5:0] OFS_INT_BEHAV = 6'h0C;
    localparam logic [5:0] OFS_END = 6'h10;
    localparam logic [5:0] OFS_LOAD = 6'h14;
    localparam logic [5:0] OFS_HYST = 6'h18;
    localparam logic [5:0] OFS_PULSE = 6'h1C;
    localparam logic [5:0] OFS_COMPARE = 6'h20;
    localparam logic [5:0] OFS_COUNT = 6'h24;
    localparam logic [5:0] OFS_STATUS = 6'h28;
    localparam logic [5:0] OFS_DIRECTION = 6'h2C;
    // Control word bits
    localparam int CTL_RESET_EN = 0;
    localparam int CTL_OUT_EN = 1;
    localparam int CTL_SW_SET = 2;
    localparam int CTL_SW_CLR = 3;
    localparam int CTL_STS_CLR = 4;
    // Status word bits
    localparam int STS_OVF = 0;
    localparam int STS_UNF = 1;
    localparam int STS_OUT = 2;
    localparam int STS_IGATE = 3;
    localparam int STS_SWGATE = 4;
    // Interrupt behaviour bits
    localparam int INT_OVF = 2;
    localparam int INT_UNF = 3;
    localparam logic [7:0] INT_FIXED = 8'h80;
    // Mode fields
    localparam int M3_GATE_FN = 7;
    localparam int M2_INV_B = 3;
    // Signal evaluation codes
    localparam logic [2:0] EV_OFF = 3'h0;
    localparam logic [2:0] EV_SINGLE = 3'h1;
    localparam logic [2:0] EV_DOUBLE = 3'h2;
    localparam logic [2:0] EV_QUAD = 3'h3;
    localparam logic [2:0] EV_PULSE = 3'h4;
    localparam logic [3:0] HWG_ON = 4'h1;
    // Output set conditions
    localparam logic [2:0] CMP_GE = 3'h1;
    localparam logic [2:0] CMP_LE = 3'h2;
    localparam logic [2:0] CMP_EQ = 3'h4;
    // Counter reset input functions
    localparam logic [2:0] RST_LEVEL = 3'h1;
    localparam logic [2:0] RST_EDGE = 3'h3;
    localparam logic [2:0] RST_ONCE = 3'h5;
    // Main counting direction
    localparam logic [1:0] DIR_NONE = 2'h0;
    localparam logic [1:0] DIR_FWD = 2'h1;
    localparam logic [1:0] DIR_BWD = 2'h2;
    // Count limits and reset values
    localparam logic [31:0] CNT_MAX = 32'h7FFF_FFFF;
    localparam logic [31:0] CNT_MIN = 32'h8000_0000;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [7:0] HYST_MIN_ON = 8'h02;
    // Pulse duration step of 2.048 ms at 100 MHz
    localparam int PULSE_STEP_US = 2048;
    localparam int CLK_MHZ = 100;
    localparam int PULSE_STEP_CYCLES = PULSE_STEP_US * CLK_MHZ;
    localparam int PULSE_TIMER_W = 26;
endpackage : ecc_pkg

/* test/ecc_enc_model.sv */
// Encoder model: two tracks stepped in Gray order on request.
// Assumes the bench calls step and that clk_in runs.
`timescale 1ns/10ps
`default_nettype none
module ecc_enc_model (
    // Clock
    input wire logic clk_in,
    // Tracks
    output logic a_out,
    output logic b_out
);
    logic [1:0] ph = 2'h0;
    // Up order 00,10,11,01: A leads, so only one track moves per step
    assign a_out = ph[1] ^ ph[0];
    assign b_out = ph[1];
    // One step, then a pause so the synchronised count settles
    task automatic step(input logic up);
        @(posedge clk_in);
        ph <= up ? ph + 2'h1 : ph - 2'h1;
        repeat (8) @(posedge clk_in);
    endtask : step
endmodule : ecc_enc_model
`default_nettype wire

/* test/testbench.sv */
// Bench for the encoder counter core: register tasks and count scenarios.
// Assumes the encoder model beside it and a 100 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module testbench import ecc_pkg::*;;
    logic clk = 1'b0, rst = 1'b1, rd = 1'b0, we = 1'b0, gate = 1'b0, crst = 1'b0;
    logic [5:0] adr = 6'h00;
    logic [31:0] wd = 32'h0000_0000, rdata, got, hi = 32'h0000_0000, h0;
    logic wrq, dout, irq, a, b, irq_seen = 1'b0;
    int failures = 0, cmp_count = 0;
    ////////////////////////////////////////
    ecc_counter #(.PULSE_UNIT_CYCLES(4)) i_ecc_counter (.CLK_IN(clk), .RESET_IN(rst),
        .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd), .AVS_WRITE_IN(we), .AVS_WRITEDATA_IN(wd),
        .AVS_BYTEENABLE_IN(4'hF), .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wrq),
        .ENC_A_IN(a), .ENC_B_IN(b), .GATE_IN(gate), .CNT_RESET_IN(crst),
        .DIG_OUT(dout), .PROC_IRQ_OUT(irq));
    ecc_enc_model i_ecc_enc_model (.clk_in(clk), .a_out(a), .b_out(b));
    // 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end
    // Catch the one-cycle interrupt and count output-high cycles
    always @(posedge clk) begin
        if (irq === 1'b1) irq_seen <= 1'b1;
        if (dout === 1'b1) hi <= hi + 32'h0000_0001;
    end
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One transfer; held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [5:0] ad, input logic [31:0] d);
        @(posedge clk);
        adr <= ad;
        wd <= d;
        we <= w;
        rd <= ~w;
        do begin
            @(posedge clk);
        end while (wrq !== 1'b0);
        got = rdata;
        we <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    task automatic rdc(input logic [5:0] ad, input logic [31:0] e);
        bus(1'b0, ad, 32'h0000_0000);
        chk(got, e);
    endtask : rdc
    task automatic st(input logic up);
        i_ecc_enc_model.step(up);
    endtask : st
    task automatic close_out;
        if (failures == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out
    // Watchdog: the scenarios need far fewer cycles than this
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        close_out();
    end
    // Scenarios in order; each leaves the count where the next expects it
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rdc(OFS_INT_BEHAV, 32'h0000_0080);
        rdc(6'h30, 32'h0000_0000);
        bus(1'b1, OFS_INT_BEHAV, 32'h0000_000C);
        bus(1'b1, OFS_LOAD, CNT_MAX - 32'h0000_0001);
        bus(1'b1, OFS_MODE_THREE, 32'h0000_0003);
        bus(1'b1, OFS_CONTROL, 32'h0000_0004);
        rdc(OFS_COUNT, CNT_MAX - 32'h0000_0001);
        st(1'b1);
        st(1'b1);
        rdc(OFS_COUNT, CNT_MIN);
        rdc(OFS_STATUS, 32'h0000_0019);
        chk(32'(irq_seen), 32'h0000_0001);
        bus(1'b1, OFS_CONTROL, 32'h0000_0010);
        rdc(OFS_STATUS, 32'h0000_0018);
        st(1'b0);
        rdc(OFS_COUNT, CNT_MAX);
        rdc(OFS_STATUS, 32'h0000_001A);
        bus(1'b1, OFS_MODE_THREE, 32'h0000_0000);
        st(1'b1);
        rdc(OFS_COUNT, CNT_MAX);
        bus(1'b1, OFS_MODE_THREE, 32'h0000_0083);
        bus(1'b1, OFS_CONTROL, 32'h0000_0008);
        st(1'b0);
        bus(1'b1, OFS_CONTROL, 32'h0000_0004);
        rdc(OFS_COUNT, CNT_MAX);
        st(1'b0);
        rdc(OFS_COUNT, CNT_MAX - 32'h0000_0001);
        bus(1'b1, OFS_MODE_THREE, 32'h0000_0003);
        bus(1'b1, OFS_LOAD, 32'h0000_0005);
        bus(1'b1, OFS_CONTROL, 32'h0000_0008);
        bus(1'b1, OFS_CONTROL, 32'h0000_0004);
        rdc(OFS_COUNT, 32'h0000_0005);
        bus(1'b1, OFS_MODE_THREE, 32'h0000_000B);
        st(1'b1);
        rdc(OFS_COUNT, 32'h0000_0005);
        gate <= 1'b1;
        st(1'b1);
        rdc(OFS_COUNT, 32'h0000_0006);
        bus(1'b1, OFS_CONTROL, 32'h0000_0008);
        bus(1'b1, OFS_CONTROL, 32'h0000_0004);
        rdc(OFS_COUNT, 32'h0000_0006);
        bus(1'b1, OFS_COMPARE, 32'h0000_0007);
        bus(1'b1, OFS_MODE_TWO, 32'h0000_0004);
        st(1'b1);
        chk(32'(dout), 32'h0000_0000);
        bus(1'b1, OFS_CONTROL, 32'h0000_0002);
        repeat (3) @(negedge clk);
        chk(32'(dout), 32'h0000_0001);
        st(1'b1);
        chk(32'(dout), 32'h0000_0000);
        bus(1'b1, OFS_MODE_TWO, 32'h0000_0014);
        crst <= 1'b1;
        repeat (6) @(posedge clk);
        rdc(OFS_COUNT, 32'h0000_0008);
        bus(1'b1, OFS_CONTROL, 32'h0000_0003);
        rdc(OFS_COUNT, 32'h0000_0005);
        crst <= 1'b0;
        bus(1'b1, OFS_PULSE, 32'h0000_0002);
        h0 = hi;
        st(1'b1);
        st(1'b1);
        repeat (20) @(posedge clk);
        chk(hi - h0, 32'h0000_0008);
        // Main directions: reload at end minus one, then at end plus one
        bus(1'b1, OFS_DIRECTION, 32'h0000_0001);
        bus(1'b1, OFS_END, 32'h0000_0009);
        st(1'b1);
        st(1'b1);
        rdc(OFS_COUNT, 32'h0000_0005);
        bus(1'b1, OFS_DIRECTION, 32'h0000_0002);
        bus(1'b1, OFS_END, 32'h0000_0003);
        st(1'b0);
        st(1'b0);
        rdc(OFS_COUNT, 32'h0000_0005);
        // One full track cycle each in single, double and inverted pulse mode
        bus(1'b1, OFS_DIRECTION, 32'h0000_0000);
        bus(1'b1, OFS_MODE_THREE, 32'h0000_0009);
        repeat (4) st(1'b1);
        rdc(OFS_COUNT, 32'h0000_0006);
        bus(1'b1, OFS_MODE_THREE, 32'h0000_000A);
        repeat (4) st(1'b1);
        rdc(OFS_COUNT, 32'h0000_0008);
        bus(1'b1, OFS_MODE_TWO, 32'h0000_0018);
        bus(1'b1, OFS_MODE_THREE, 32'h0000_000C);
        repeat (4) st(1'b1);
        rdc(OFS_COUNT, 32'h0000_0007);
        // Output holds inside the hysteresis band and drops at its edge
        bus(1'b1, OFS_MODE_THREE, 32'h0000_000B);
        bus(1'b1, OFS_PULSE, 32'h0000_0000);
        bus(1'b1, OFS_HYST, 32'h0000_0003);
        bus(1'b1, OFS_MODE_TWO, 32'h0000_0001);
        st(1'b0);
        chk(32'(dout), 32'h0000_0001);
        st(1'b0);
        st(1'b0);
        chk(32'(dout), 32'h0000_0000);
        close_out();
    end
endmodule : testbench
`default_nettype wire
